// ===== src/wss_seq.sv
// eight-entry waveform sequence slot bank with its playback walker
// assumes a library engine that takes effect_start/effect_index and
// answers with a one-cycle effect_done when the effect has finished
`timescale 1ns/100ps
`default_nettype none
module wss_seq #(
  parameter int STEP_CYCLES = wss_pkg::WSS_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // library playback
  output logic effect_start,
  output logic [wss_pkg::WSS_FIELD_W-1:0] effect_index,
  input wire logic effect_done,
  // status
  output logic seq_busy,
  output logic idle_active
);
  import wss_pkg::*;

  localparam logic [WSS_IDX_W-1:0] IDX_LAST = WSS_IDX_W'(WSS_SLOT_COUNT - 1);

  wss_state_t state;
  logic [7:0] slots [WSS_SLOT_COUNT];
  logic [WSS_IDX_W-1:0] idx;
  logic [7:0] cur;
  logic cur_wait;
  logic [WSS_FIELD_W-1:0] cur_field;
  logic go_wr;
  logic timer_start;
  logic timer_done;
  logic step_end;

  // slot storage; slots five and six sit at 0x13 and 0x14
  for (genvar i = 0; i < WSS_SLOT_COUNT; i++) begin : g_slot
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        slots[i] <= WSS_SLOT_RESET;
      end else if (reg_wr && reg_addr == 8'(WSS_SLOT_FIRST + i)) begin
        slots[i] <= reg_wdata;
      end
    end
  end

  // current slot split into wait flag and field
  assign cur = slots[idx];
  assign cur_wait = cur[WSS_WAIT_BIT];
  assign cur_field = cur[WSS_FIELD_W-1:0];
  assign go_wr = reg_wr && reg_addr == WSS_GO_ADDR && reg_wdata[WSS_GO_BIT];
  assign timer_start = state == WSS_FETCH && cur_wait;
  // a finished effect or a finished idle time both move the walker on
  assign step_end = (state == WSS_PLAY && effect_done) || (state == WSS_WAIT && timer_done);

  // readback, one cycle behind the address; the go bit reads as busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= WSS_READ_ZERO;
    end else if (reg_addr == WSS_GO_ADDR) begin
      reg_rdata <= 8'(seq_busy) << WSS_GO_BIT;
    end else if (reg_addr >= WSS_SLOT_FIRST && reg_addr <= WSS_SLOT_LAST) begin
      reg_rdata <= slots[WSS_IDX_W'(reg_addr - WSS_SLOT_FIRST)];
    end else begin
      reg_rdata <= WSS_READ_ZERO;
    end
  end

  // walker; a go written while busy is ignored so a running sequence is not cut
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= WSS_IDLE;
      idx <= '0;
    end else begin
      unique case (state)
        WSS_IDLE: begin
          if (go_wr) begin
            idx <= '0;
            state <= WSS_FETCH;
          end
        end
        WSS_FETCH: begin
          if (!cur_wait && cur_field == '0) begin
            state <= WSS_IDLE;
          end else if (cur_wait) begin
            state <= WSS_WAIT;
          end else begin
            state <= WSS_PLAY;
          end
        end
        WSS_PLAY, WSS_WAIT: begin
          if (step_end) begin
            if (idx == IDX_LAST) begin
              state <= WSS_IDLE;
            end else begin
              idx <= idx + 1'b1;
              state <= WSS_FETCH;
            end
          end
        end
        default: state <= WSS_IDLE;
      endcase
    end
  end

  // effect request to the library; field is used unchanged as the index
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      effect_start <= 1'b0;
      effect_index <= '0;
    end else begin
      effect_start <= state == WSS_FETCH && !cur_wait && cur_field != '0;
      if (state == WSS_FETCH && !cur_wait) begin
        effect_index <= cur_field;
      end
    end
  end

  // status flags, registered so they track the walker one cycle behind
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_busy <= 1'b0;
      idle_active <= 1'b0;
    end else begin
      seq_busy <= state != WSS_IDLE;
      idle_active <= state == WSS_WAIT;
    end
  end

  wss_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timer_start),
    .steps(cur_field),
    .done(timer_done)
  );

  a_wait_plays_nothing: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_FETCH && cur_wait |=> state == WSS_WAIT && !effect_start
      ##1 idle_active && !effect_start)
    else $error("effect requested during an idle slot");

  a_effect_from_field: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_FETCH && !cur_wait && cur_field != '0
      |=> state == WSS_PLAY && effect_start)
    else $error("effect slot did not start playback");

  a_index_is_field: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_FETCH && !cur_wait |=> effect_index == $past(cur_field))
    else $error("library index differs from slot field");

  a_go_first_slot: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_IDLE && go_wr |=> state == WSS_FETCH && idx == '0 ##1 seq_busy)
    else $error("go did not start at the first slot");

  a_advance_next: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_PLAY && effect_done && idx != IDX_LAST
      |=> state == WSS_FETCH && idx == $past(idx) + 1'b1)
    else $error("walker did not advance to the next slot");

  a_stop_on_zero: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_FETCH && !cur_wait && cur_field == '0
      |=> state == WSS_IDLE && !effect_start ##1 !seq_busy)
    else $error("walker ran past a zero identifier");

  a_stop_after_last: assert property (@(posedge clk_sys) disable iff (rst)
    step_end && idx == IDX_LAST |=> state == WSS_IDLE)
    else $error("walker ran past the last slot");

  a_resume_after_idle: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_WAIT && timer_done && idx != IDX_LAST
      |=> state == WSS_FETCH && idx == $past(idx) + 1'b1)
    else $error("walker did not resume after an idle time");

  // holding checks: outside fetch the walker moves only on a go, a finished effect or a finished idle
  a_busy_go_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_PLAY && go_wr && !effect_done
      |=> state == WSS_PLAY && $stable(idx))
    else $error("go while busy disturbed the walker");

  a_play_until_done: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_PLAY && !effect_done
      |=> state == WSS_PLAY)
    else $error("walker left an effect before it finished");

  a_fetch_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_FETCH
      |=> state != WSS_FETCH)
    else $error("walker stayed in fetch");

  a_idle_until_timer: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_WAIT && !timer_done
      |=> state == WSS_WAIT)
    else $error("idle time cut short");

  a_wait_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_WAIT
      |-> !effect_start)
    else $error("effect request while idling");

  a_effect_only_play: assert property (@(posedge clk_sys) disable iff (rst)
    effect_start
      |-> state == WSS_PLAY)
    else $error("effect request outside an effect slot");

  a_index_held: assert property (@(posedge clk_sys) disable iff (rst)
    state != WSS_FETCH
      |=> $stable(effect_index))
    else $error("library index changed without a fetch");

  a_stopped_stays: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_IDLE && !go_wr
      |=> state == WSS_IDLE && !effect_start)
    else $error("stopped walker moved without a go");

  a_busy_while_walking: assert property (@(posedge clk_sys) disable iff (rst)
    state == WSS_PLAY || state == WSS_WAIT
      |-> seq_busy)
    else $error("busy low while a slot is being played");

  a_last_no_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    state != WSS_IDLE && idx == IDX_LAST
      |=> idx == IDX_LAST)
    else $error("walker wrapped past the last slot");

endmodule : wss_seq
`default_nettype wire

// ===== src/wss_pkg.sv
// constants for the waveform sequence slot bank and its playback walker
// assumes one 200 MHz system clock and a simple byte-wide register port
package wss_pkg;
  // register map
  localparam logic [7:0] WSS_GO_ADDR = 8'h0c;
  localparam logic [7:0] WSS_SLOT_FIRST = 8'h0f;
  localparam logic [7:0] WSS_SLOT_FIVE_ADDR = 8'h13;
  localparam logic [7:0] WSS_SLOT_SIX_ADDR = 8'h14;
  localparam logic [7:0] WSS_SLOT_LAST = 8'h16;
  localparam int WSS_SLOT_COUNT = 8;
  localparam int WSS_IDX_W = 3;
  // field layout of a slot
  localparam int WSS_WAIT_BIT = 7;
  localparam int WSS_FIELD_W = 7;
  localparam int WSS_GO_BIT = 0;
  localparam logic [7:0] WSS_SLOT_RESET = 8'h00;
  localparam logic [7:0] WSS_READ_ZERO = 8'h00;
  // timing
  localparam int WSS_STEP_TIME_NS = 10000000;
  localparam int WSS_CLK_PERIOD_NS = 5;
  localparam int WSS_STEP_CYCLES = WSS_STEP_TIME_NS / WSS_CLK_PERIOD_NS;
  // walker states
  typedef enum logic [3:0] {
    WSS_IDLE  = 4'b0001,
    WSS_FETCH = 4'b0010,
    WSS_PLAY  = 4'b0100,
    WSS_WAIT  = 4'b1000
  } wss_state_t;
endpackage : wss_pkg

// ===== src/wss_step_timer.sv
// idle-time generator: counts a number of 10 ms steps off the system clock
// assumes start is a one-cycle pulse given only while the timer is not running
`timescale 1ns/100ps
`default_nettype none
module wss_step_timer #(
  parameter int STEP_CYCLES = wss_pkg::WSS_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [wss_pkg::WSS_FIELD_W-1:0] steps,
  // result
  output logic done
);
  import wss_pkg::*;

  localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);

  logic running;
  logic [31:0] cnt;
  logic [WSS_FIELD_W-1:0] steps_left;
  logic [WSS_FIELD_W-1:0] steps_q;
  logic [31:0] elapsed;

  // step counter; a zero step count ends at once rather than hanging the walker
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      cnt <= 32'h0;
      steps_left <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= 32'h0;
        steps_left <= steps;
        running <= (steps != '0);
        done <= (steps == '0);
      end else if (running) begin
        if (cnt == STEP_LAST) begin
          cnt <= 32'h0;
          steps_left <= steps_left - 1'b1;
          if (steps_left == WSS_FIELD_W'(1)) begin
            running <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  end

  // helper for checking only: cycles since start and the step count taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      elapsed <= 32'h0;
      steps_q <= '0;
    end else if (start) begin
      elapsed <= 32'h0;
      steps_q <= steps;
    end else if (running) begin
      elapsed <= elapsed + 32'h1;
    end
  end

  a_step_time_exact: assert property (@(posedge clk_sys) disable iff (rst)
    done |-> elapsed == 32'(steps_q) * 32'(STEP_CYCLES))
    else $error("idle time differs from steps times step length");

endmodule : wss_step_timer
`default_nettype wire

// ===== test/wss_seq_tb_top.sv
// self-checking bench for the sequence slot bank and its playback walker
// assumes wss_pkg is compiled first; the bench plays the effect library
`timescale 1ns/100ps
`default_nettype none
module wss_seq_tb_top;
  import wss_pkg::*;
  localparam int SC = 4;
  localparam int GAP = 2; // one fetch edge plus the registered start, after go or done
  logic clk_sys, rst, reg_wr, effect_done, effect_start, seq_busy, idle_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [WSS_FIELD_W-1:0] effect_index;
  int num_errors, tests_run, seed, cyc, last_ev, dcnt, idle_cnt;
  bit go_seen;
  logic [7:0] slot [8];
  logic [6:0] got_idx [$];
  int got_gap [$];
  wss_seq #(.STEP_CYCLES(SC)) u_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .effect_start(effect_start), .effect_index(effect_index), .effect_done(effect_done),
    .seq_busy(seq_busy), .idle_active(idle_active));
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // library stand-in: ends each effect 1..4 cycles late, logs gaps
  always @(posedge clk_sys) begin
    effect_done <= (dcnt == 1);
    // only the go that starts a playback counts; a go while busy is refused
    if (reg_wr && reg_addr == WSS_GO_ADDR && reg_wdata[WSS_GO_BIT] && !go_seen) begin
      last_ev = cyc;
      go_seen = 1'b1;
    end
    if (effect_done) last_ev = cyc;
    if (idle_active) idle_cnt++;
    if (effect_start) begin
      got_idx.push_back(effect_index);
      got_gap.push_back(cyc - last_ev);
      dcnt = 1 + ($random(seed) & 3);
    end else if (dcnt > 0) dcnt--;
    cyc++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 chk(reg_rdata, exp);
  endtask : rd
  // expected order and spacing come from the bench's copy of the slots
  task automatic play(input bit poke);
    logic [6:0] ei [$];
    int eg [$];
    int extra, iexp, nid, n;
    got_idx.delete();
    got_gap.delete();
    idle_cnt = 0;
    extra = 0;
    iexp = 0;
    nid = 0;
    go_seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(WSS_SLOT_FIRST + 8'(i), slot[i]);
    end
    for (int i = 0; i < 8 && slot[i] != 8'h00; i++) begin
      if (slot[i][7]) begin
        extra += 2 + slot[i][6:0] * SC;
        iexp += slot[i][6:0] * SC;
        nid++;
      end else begin
        ei.push_back(slot[i][6:0]);
        eg.push_back(extra);
        extra = 0;
      end
    end
    wr(WSS_GO_ADDR, 8'h00);
    wr(WSS_GO_ADDR, 8'h01);
    if (poke) begin
      wr(WSS_GO_ADDR, 8'h01);
      rd(WSS_GO_ADDR, 8'h01);
    end
    // busy lags the go by a cycle, so let it rise before polling
    repeat (2) @(posedge clk_sys);
    #1;
    n = 0;
    while (seq_busy !== 1'b0 && n < 20000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n < 20000, 1);
    rd(WSS_GO_ADDR, 8'h00);
    chk(got_idx.size(), ei.size());
    for (int i = 0; i < ei.size() && i < got_idx.size(); i++) begin
      chk(got_idx[i], ei[i]);
      chk(got_gap[i], GAP + eg[i]);
    end
    // each idle slot shows one cycle more than its steps times SC: the cycle that takes done
    chk(idle_cnt, iexp + nid);
  endtask : play
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // watchdog sized well beyond the three playbacks
  initial begin
    #(5 * 80000);
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    seed = 32'hb028;
    {rst, reg_wr, effect_done, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {num_errors, tests_run, cyc, last_ev, dcnt, idle_cnt} = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(WSS_SLOT_FIVE_ADDR, WSS_SLOT_RESET);
    rd(WSS_SLOT_SIX_ADDR, WSS_SLOT_RESET);
    wr(8'h20, 8'h5a);
    rd(8'h20, WSS_READ_ZERO);
    for (int i = 0; i < 4; i++) begin
      slot[0] = 8'($random(seed));
      wr(WSS_SLOT_FIVE_ADDR + 8'(i & 1), slot[0]);
      rd(WSS_SLOT_FIVE_ADDR + 8'(i & 1), slot[0]);
    end
    // effects everywhere, idles in slot three and slot six
    for (int i = 0; i < 8; i++) begin
      slot[i] = {1'b0, 7'($random(seed) | 1)};
    end
    slot[2] = 8'h82;
    slot[5] = 8'h81;
    play(1'b1);
    // zero-length idle first, slot five stops the walk
    slot[0] = 8'h80;
    slot[4] = 8'h00;
    play(1'b0);
    // empty first slot plays nothing
    slot[0] = 8'h00;
    play(1'b0);
    wrap_up();
  end
endmodule : wss_seq_tb_top
`default_nettype wire
